// file: tb/erf_props.sv
// Checker: port properties of the erase result block
module erf_props import erf_pkg::*; (
	// APB side
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Flash side and interrupt
	input wire logic        error_protect_flag,
	input wire logic        erase_fault,
	input wire logic        erase_busy,
	input wire logic        array_erase,
	input wire logic        irq
);
	logic [7:0] key_r;
	logic [7:0] blk_r;
	wire        wr = psel && penable && pready && pwrite;
	wire        rd_res = psel && penable && pready && !pwrite &&
		paddr == ERF_ADDR_RESULT;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_r <= 8'h00;
			blk_r <= 8'h00;
		end else if (wr && paddr == ERF_ADDR_KEY) begin
			key_r <= pwdata[7:0];
		end else if (wr && paddr == ERF_ADDR_BLOCK) begin
			blk_r <= pwdata[7:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_setup; psel && !penable |=> pready; endproperty
	a_setup: assert property (p_setup) else $error("no ready after setup");
	property p_idle; !psel |=> !pready; endproperty
	a_idle: assert property (p_idle) else $error("ready without request");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_key; $rose(array_erase) |-> key_r == ERF_KEY_OK; endproperty
	a_key: assert property (p_key) else $error("erase with bad key");
	property p_blk; $rose(array_erase) |-> blk_r <= ERF_BLOCK_LAST; endproperty
	a_blk: assert property (p_blk) else $error("erase bad block");
	property p_prot; $rose(array_erase) |-> !$past(error_protect_flag, 2);
	endproperty
	a_prot: assert property (p_prot) else $error("erase protected");
	property p_sum; rd_res |-> (prdata[0] == |prdata[6:3]) &&
		(prdata[7] == 1'b0) && (prdata[2:1] == 2'b00); endproperty
	a_sum: assert property (p_sum) else $error("fail bit wrong");
	property p_len; $rose(array_erase) |-> array_erase[*6]; endproperty
	a_len: assert property (p_len) else $error("erase cut short");
	property p_busy; array_erase |-> erase_busy; endproperty
	a_busy: assert property (p_busy) else $error("erase while idle");
endmodule
bind erf_top erf_props u_props (
	.pclk               (pclk),
	.presetn            (presetn),
	.psel               (psel),
	.penable            (penable),
	.pwrite             (pwrite),
	.paddr              (paddr),
	.pwdata             (pwdata),
	.prdata             (prdata),
	.pready             (pready),
	.pslverr            (pslverr),
	.error_protect_flag (error_protect_flag),
	.erase_fault        (erase_fault),
	.erase_busy         (erase_busy),
	.array_erase        (array_erase),
	.irq                (irq)
);

// file: tb/testbench.sv
// Testbench: erase result flags driven over APB
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
	num_errors++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import erf_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [7:0]  prev = ERF_RESULT_RST;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        error_protect_flag = 0, erase_fault = 0;
	logic        pready, pslverr, erase_busy, array_erase, irq, rd_err;
	int          num_errors = 0, n_checks = 0, n_erase = 0, n_busy = 0;
	erf_top uut (
		.pclk               (pclk),
		.presetn            (presetn),
		.psel               (psel),
		.penable            (penable),
		.pwrite             (pwrite),
		.paddr              (paddr),
		.pwdata             (pwdata),
		.prdata             (prdata),
		.pready             (pready),
		.pslverr            (pslverr),
		.error_protect_flag (error_protect_flag),
		.erase_fault        (erase_fault),
		.erase_busy         (erase_busy),
		.array_erase        (array_erase),
		.irq                (irq)
	);
	initial forever #5 pclk = ~pclk;
	// Cycles with the array erased and with the sequencer busy
	always @(posedge pclk) begin
		if (array_erase === 1'b1)
			n_erase++;
		if (erase_busy === 1'b1)
			n_busy++;
	end
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1) begin
			num_errors++;
			close_out();
		end
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_idle();
		int i;
		i = 0;
		do begin
			apb(0, ERF_ADDR_STATUS, 32'h0);
			i++;
		end while (rd[0] !== 1'b1 && i < 40);
		if (rd[0] !== 1'b1) begin
			num_errors++;
			close_out();
		end
	endtask
	task automatic erase(input logic [7:0] k, s, b, input logic p, f,
		input logic [7:0] e);
		int   e0, b0;
		logic go;
		go = k == ERF_KEY_OK && s != ERF_SEL_BOOT &&
			b <= ERF_BLOCK_LAST && !p;
		error_protect_flag <= p;
		erase_fault <= f;
		apb(1, ERF_ADDR_KEY, {24'h0, k});
		apb(1, ERF_ADDR_SEL, {24'h0, s});
		apb(1, ERF_ADDR_BLOCK, {24'h0, b});
		apb(0, ERF_ADDR_RESULT, 32'h0);
		`CHK("held", {24'h0, prev}, rd)
		e0 = n_erase;
		b0 = n_busy;
		apb(1, ERF_ADDR_CTRL, 32'h3); // main array only
		if (go) begin
			apb(0, ERF_ADDR_RESULT, 32'h0);
			`CHK("held", {24'h0, prev}, rd)
		end
		// A fault seen early in the erase must still be reported
		erase_fault <= 1'b0;
		wait_idle();
		apb(0, ERF_ADDR_RESULT, 32'h0);
		`CHK("result", {24'h0, e}, rd)
		`CHK("erased", go, n_erase != e0)
		`CHK("busy", 1'b1, n_busy != b0)
		prev = e;
		$display("test erase %h done", e);
	endtask
	task automatic chg_test();
		apb(1, ERF_ADDR_CTRL, 32'h3); // main array only
		apb(1, ERF_ADDR_KEY, {24'h0, ERF_KEY_OK});
		wait_idle();
		apb(0, ERF_ADDR_RESULT, 32'h0);
		`CHK("changed", 32'h21, rd)
		apb(0, ERF_ADDR_CTRL, 32'h0);
		`CHK("chg flag", 32'ha, rd)
		prev = 8'h21;
		$display("test chg done");
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h40, 32'h0);
		`CHK("unmapped", ERF_ZERO32, rd)
		`CHK("slverr", 1'b1, rd_err)
		apb(1, ERF_ADDR_IRQ_EN, 32'h3);
		`CHK("no slverr", 1'b0, rd_err)
		erase(8'h00, 8'h00, 8'h00, 0, 0, 8'h11);
		erase(8'h5a, 8'h00, 8'h00, 0, 0, 8'h00);
		erase(8'h5a, 8'h00, 8'h0a, 0, 0, 8'h09);
		erase(8'h5a, 8'h00, 8'h09, 0, 0, 8'h00);
		erase(8'h5a, 8'haa, 8'h00, 0, 0, 8'h21);
		erase(8'h5a, 8'h00, 8'h00, 1, 0, 8'h41);
		erase(8'h5a, 8'h00, 8'h00, 0, 1, 8'h21);
		erase(8'h5a, 8'h00, 8'h00, 0, 0, 8'h00); // retry after error
		chg_test();
		`CHK("irq on", 1'b1, irq)
		apb(1, ERF_ADDR_IRQ_CL, 32'h3);
		apb(0, ERF_ADDR_IRQ_ST, 32'h0);
		`CHK("irq clr", 32'h0, rd)
		`CHK("irq off", 1'b0, irq)
		apb(1, ERF_ADDR_IRQ_EN, 32'h0);
		erase(8'h00, 8'h00, 8'h00, 0, 0, 8'h11);
		apb(0, ERF_ADDR_IRQ_ST, 32'h0);
		`CHK("irq st", 32'h3, rd)
		`CHK("irq mask", 1'b0, irq)
		apb(1, ERF_ADDR_IRQ_EN, 32'h3);
		apb(0, ERF_ADDR_IRQ_ST, 32'h0);
		`CHK("irq unmask", 1'b1, irq)
		$display("test irq done");
		close_out();
	end
endmodule

// file: verilog/erf_pkg.sv
// Package: register map, field layout and constants of the erase result block
package erf_pkg;

	localparam logic [7:0]  ERF_ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ERF_ADDR_KEY    = 8'h04;
	localparam logic [7:0]  ERF_ADDR_SEL    = 8'h08;
	localparam logic [7:0]  ERF_ADDR_BLOCK  = 8'h0c;
	localparam logic [7:0]  ERF_ADDR_RESULT = 8'h10;
	localparam logic [7:0]  ERF_ADDR_STATUS = 8'h14;
	localparam logic [7:0]  ERF_ADDR_IRQ_ST = 8'h18;
	localparam logic [7:0]  ERF_ADDR_IRQ_EN = 8'h1c;
	localparam logic [7:0]  ERF_ADDR_IRQ_CL = 8'h20;

	localparam int ERF_BIT_PROT  = 6;
	localparam int ERF_BIT_EXEC  = 5;
	localparam int ERF_BIT_KEY   = 4;
	localparam int ERF_BIT_BLOCK = 3;
	localparam int ERF_BIT_FAIL  = 0;

	localparam int ERF_CTRL_START = 0;
	localparam int ERF_CTRL_MAIN  = 1;
	localparam int ERF_CTRL_ERROR_PROTECT_FLAG  = 2;
	localparam int ERF_CTRL_CHG   = 3;

	localparam int ERF_IRQ_DONE = 0;
	localparam int ERF_IRQ_ERR  = 1;
	localparam int ERF_IRQ_W    = 2;

	localparam logic [7:0]  ERF_KEY_OK     = 8'h5a;
	localparam logic [7:0]  ERF_SEL_BOOT   = 8'haa;
	localparam logic [7:0]  ERF_BLOCK_LAST = 8'h09;
	localparam logic [7:0]  ERF_RESULT_RST = 8'h00;
	localparam logic [3:0]  ERF_ERASE_CYC  = 4'h8;
	localparam logic [31:0] ERF_ZERO32     = 32'h0000_0000;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} erf_apb_req_t;

	typedef enum logic [2:0] {
		ERF_IDLE  = 3'b001,
		ERF_CHECK = 3'b010,
		ERF_ERASE = 3'b100
	} erf_state_t;

endpackage

// file: verilog/erf_sticky.sv
// Sticky event bit with set priority over clear
module erf_sticky (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Event and clear
	input  wire logic set_i,
	input  wire logic clr_i,
	// State
	output logic      q
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			q <= 1'b0;
		else if (set_i)
			q <= 1'b1;
		else if (clr_i)
			q <= 1'b0;
	end
endmodule

// file: verilog/erf_top.sv
// Erase sequencer with result flag byte behind an APB slave
// Contract
// R1 - Protection state sets result bit six
// R2 - Bit six mirrors the error protect flag
// R3 - Bit five flags failed or disturbed erase
// R4 - Main erase with boot selected fails, nothing erased
// R5 - Software never erases boot array in user mode
// R6 - Key checked against 5a, bit four
// R7 - Software retries erase after execution error
// R8 - Bit three flags block number out of range
// R9 - Bit zero flags any error
// R10 - All result bits update together, then hold
module erf_top (
	// APB clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// APB request
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	// APB answer
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// Flash controller status
	input  wire logic         error_protect_flag,
	input  wire logic         erase_fault,
	// Erase control to array
	output logic              erase_busy,
	output logic              array_erase,
	// Interrupt
	output logic              irq
);
	import erf_pkg::*;

	erf_apb_req_t req;
	erf_state_t   state_r;
	logic [7:0]   flash_unlock_reg_r;
	logic [7:0]   array_select_reg_r;
	logic [7:0]   block_r;
	logic         main_r;
	logic         chg_r;
	logic         fault_r;
	logic [7:0]   erase_result_flags_r;
	logic [3:0]   cnt_r;
	logic [ERF_IRQ_W-1:0] irq_en_r;
	logic [ERF_IRQ_W-1:0] irq_st;
	logic [ERF_IRQ_W-1:0] irq_set;
	logic         wr_acc;
	logic         rd_acc;
	logic         clr_wr;
	logic         start;
	logic         key_bad;
	logic         sel_bad;
	logic         blk_bad;
	logic         done;
	logic         exec_err;
	logic [7:0]   result_nxt;
	logic         mapped;
	logic [31:0]  rd_nxt;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite,
		paddr: paddr, pwdata: pwdata};
	assign wr_acc = req.psel && req.penable && req.pwrite;
	assign rd_acc = req.psel && req.penable && !req.pwrite;
	assign start  = wr_acc && req.paddr == ERF_ADDR_CTRL &&
		req.pwdata[ERF_CTRL_START] && state_r == ERF_IDLE;
	assign clr_wr = wr_acc && req.paddr == ERF_ADDR_IRQ_CL;

	// Writable configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_unlock_reg_r <= 8'h00;
			array_select_reg_r <= 8'h00;
			block_r            <= 8'h00;
			irq_en_r           <= '0;
		end else if (wr_acc) begin
			case (req.paddr)
			ERF_ADDR_KEY:    flash_unlock_reg_r <= req.pwdata[7:0];
			ERF_ADDR_SEL:    array_select_reg_r <= req.pwdata[7:0];
			ERF_ADDR_BLOCK:  block_r <= req.pwdata[7:0];
			ERF_ADDR_IRQ_EN: irq_en_r <= req.pwdata[ERF_IRQ_W-1:0];
			default: ;
			endcase
		end
	end

	// Request latch: main array target and register change during erase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_r <= 1'b0;
			chg_r  <= 1'b0;
		end else if (start) begin
			main_r <= req.pwdata[ERF_CTRL_MAIN];
			chg_r  <= 1'b0;
		end else if (state_r != ERF_IDLE && wr_acc &&
			(req.paddr == ERF_ADDR_KEY || req.paddr == ERF_ADDR_SEL ||
			req.paddr == ERF_ADDR_BLOCK)) begin
			chg_r  <= 1'b1;
		end
	end

	assign key_bad = flash_unlock_reg_r != ERF_KEY_OK; // [R6]
	assign sel_bad = main_r && array_select_reg_r == ERF_SEL_BOOT; // [R4]
	assign blk_bad = block_r > ERF_BLOCK_LAST; // [R8]

	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ERF_IDLE;
			cnt_r   <= 4'h0;
		end else begin
			case (state_r)
			ERF_IDLE: begin
				cnt_r <= 4'h0;
				if (start)
					state_r <= ERF_CHECK;
			end
			ERF_CHECK: begin
				// Key, block and selection checked before erasure [R6]
				if (key_bad || sel_bad || blk_bad || error_protect_flag)
					state_r <= ERF_IDLE;
				else
					state_r <= ERF_ERASE;
			end
			ERF_ERASE: begin
				cnt_r <= cnt_r + 4'h1;
				if (cnt_r == ERF_ERASE_CYC - 4'h1)
					state_r <= ERF_IDLE;
			end
			default: state_r <= ERF_IDLE;
			endcase
		end
	end

	assign done = (state_r == ERF_CHECK &&
		(key_bad || sel_bad || blk_bad || error_protect_flag)) ||
		(state_r == ERF_ERASE && cnt_r == ERF_ERASE_CYC - 4'h1);
	// Fault seen in any erase cycle is kept until the next start clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fault_r <= 1'b0;
		else if (start)
			fault_r <= 1'b0;
		else if (state_r == ERF_ERASE && erase_fault)
			fault_r <= 1'b1; // [R3]
	end

	assign exec_err = sel_bad || chg_r || fault_r || // [R3] [R4]
		(state_r == ERF_ERASE && erase_fault);

	always_comb begin
		result_nxt = ERF_RESULT_RST;
		result_nxt[ERF_BIT_PROT]  = error_protect_flag; // [R1] [R2]
		result_nxt[ERF_BIT_EXEC]  = exec_err; // [R3]
		result_nxt[ERF_BIT_KEY]   = key_bad; // [R6]
		result_nxt[ERF_BIT_BLOCK] = blk_bad; // [R8]
		result_nxt[ERF_BIT_FAIL]  = error_protect_flag || exec_err ||
			key_bad || blk_bad; // [R9]
	end

	// Result byte written once per erase, then held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			erase_result_flags_r <= ERF_RESULT_RST;
		else if (done)
			erase_result_flags_r <= result_nxt; // [R10]
	end

	// Array drive: never erased on a refused request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erase_busy  <= 1'b0;
			array_erase <= 1'b0;
		end else begin
			erase_busy  <= state_r != ERF_IDLE;
			array_erase <= state_r == ERF_ERASE && !done; // [R4]
		end
	end

	// Interrupt status
	assign irq_set = {done && result_nxt[ERF_BIT_FAIL], done};
	for (genvar i = 0; i < ERF_IRQ_W; i++) begin : g_irq
		erf_sticky u_st (
			.pclk    (pclk),
			.presetn (presetn),
			.set_i   (irq_set[i]),
			.clr_i   (clr_wr && req.pwdata[i]),
			.q       (irq_st[i])
		);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(irq_st & irq_en_r);
	end

	// APB read path
	always_comb begin
		rd_nxt = ERF_ZERO32;
		mapped = 1'b1;
		case (req.paddr)
		ERF_ADDR_CTRL: begin
			rd_nxt[ERF_CTRL_START] = state_r != ERF_IDLE;
			rd_nxt[ERF_CTRL_MAIN]  = main_r;
			rd_nxt[ERF_CTRL_ERROR_PROTECT_FLAG]  = error_protect_flag;
			rd_nxt[ERF_CTRL_CHG]   = chg_r;
		end
		ERF_ADDR_KEY:    rd_nxt[7:0] = flash_unlock_reg_r;
		ERF_ADDR_SEL:    rd_nxt[7:0] = array_select_reg_r;
		ERF_ADDR_BLOCK:  rd_nxt[7:0] = block_r;
		ERF_ADDR_RESULT: rd_nxt[7:0] = erase_result_flags_r;
		ERF_ADDR_STATUS: rd_nxt[2:0] = state_r;
		ERF_ADDR_IRQ_ST: rd_nxt[ERF_IRQ_W-1:0] = irq_st;
		ERF_ADDR_IRQ_EN: rd_nxt[ERF_IRQ_W-1:0] = irq_en_r;
		ERF_ADDR_IRQ_CL: ;
		default: mapped = 1'b0;
		endcase
	end

	// Zero wait: answer registered in setup, ready during access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= ERF_ZERO32;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= req.psel && !req.penable;
			pslverr <= req.psel && !req.penable && !mapped;
			if (req.psel && !req.penable && !req.pwrite)
				prdata <= rd_nxt;
		end
	end
endmodule
